//--- hw/tx_abort_tracker.sv
// Read/write-set tracking and abort decision for one logical processor
module tx_abort_tracker
    import tx_abort_pkg::*;
#(
    parameter int WAYS       = L1_WAYS,
    parameter int SETS       = L1_SETS,
    parameter int BLOOM_BITS = BLOOM_SIZE
) (
    input  logic               pclk,
    input  logic               presetn,
    input  logic [11:0]        paddr,
    input  logic               psel,
    input  logic               penable,
    input  logic               pwrite,
    input  logic [31:0]        pwdata,
    output logic [31:0]        prdata,
    output logic               pready,
    output logic               pslverr,
    input  mem_access_s        acc,
    input  snoop_s             snoop,
    input  evict_s             evict,
    input  core_event_s        core_ev,
    output logic               tx_active,
    output logic               abort_pulse,
    output abort_cause_e       abort_cause,
    output logic               commit_pulse,
    output logic               exc_suppress
);

    localparam int WAY_W = $clog2(WAYS);

    if (WAYS < 2 || WAYS > L1_WAYS || (1 << WAY_W) != WAYS ||
        SETS != (1 << SET_W) || BLOOM_BITS != (1 << BLOOM_W)) begin : g_chk
        $error("tx_abort_tracker: unsupported geometry");
    end

    function automatic logic [SET_W-1:0] set_of(input logic [ADDR_W-1:0] a);
        return a[LINE_OFS_W +: SET_W];
    endfunction

    function automatic logic [TAG_W-1:0] tag_of(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: TAG_W];
    endfunction

    function automatic logic [BLOOM_W-1:0] bloom_idx(
        input logic [TAG_W-1:0] t, input logic [SET_W-1:0] s);
        logic [TAG_W+SET_W-1:0] ln;
        ln = {t, s};
        return ln[BLOOM_W-1:0] ^ ln[2*BLOOM_W-1:BLOOM_W];
    endfunction

    function automatic logic [WAY_W-1:0] first_one(input logic [WAYS-1:0] v);
        logic [WAY_W-1:0] r;
        r = '0;
        for (int i = WAYS - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = WAY_W'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [ADDR_W-1:0] last_byte(
        input logic [ADDR_W-1:0] a, input logic [1:0] sz);
        return a + ADDR_W'((32'd1 << sz) - 32'd1);
    endfunction

    function automatic logic [DATA_W-1:0] size_mask(input logic [1:0] sz);
        logic [DATA_W-1:0] m;
        m = '1;
        return m >> (DATA_W - (8 << sz));
    endfunction

    tx_state_e         state_ff;
    abort_cause_e      cause_ff;
    logic [WAYS-1:0]   rd_ff [SETS];
    logic [WAYS-1:0]   wr_ff [SETS];
    logic [TAG_W-1:0]  tag_ff [SETS][WAYS];
    logic [BLOOM_BITS-1:0] bloom_ff;
    logic [ADDR_W-1:0] lock_addr_ff;
    logic [1:0]        lock_size_ff;
    logic [DATA_W-1:0] lock_val_ff;
    logic              narrow_used_ff;
    logic              wide_used_ff;
    logic [CTRL_W-1:0] ctrl_ff;
    logic [CNT_W-1:0]  abort_cnt_ff;
    logic              abort_ff;
    logic              commit_ff;
    logic              active_ff;
    logic              supp_ff;
    logic              pready_ff;
    logic              pslverr_ff;
    logic [31:0]       prdata_ff;

    logic [SET_W-1:0]  acc_set;
    logic [SET_W-1:0]  snp_set;
    logic [TAG_W-1:0]  acc_tag;
    logic [WAYS-1:0]   a_hit;
    logic [WAYS-1:0]   a_free;
    logic [WAYS-1:0]   a_ronly;
    logic [WAYS-1:0]   s_hit_rd;
    logic [WAYS-1:0]   s_hit_wr;
    logic [WAY_W-1:0]  way_sel;
    logic [WAY_W-1:0]  ev_way;
    logic              spill;
    logic              cap_fail;
    logic              in_tx;
    logic              bloom_en;
    logic              snp_conflict;
    logic              snp_lock;
    logic              lk_exact;
    logic              lk_ovl;
    logic              rel_ok;
    logic              lock_viol;
    logic              cross_line;
    logic              vec_abort;
    logic              ev_rd;
    logic              ev_fail;
    logic              do_abort;
    logic              do_commit;
    logic              do_mark;
    logic              start_elide;
    logic              suppress;
    abort_cause_e      nxt_cause;

    assign in_tx    = state_ff != ST_IDLE;
    assign bloom_en = ctrl_ff[CTRL_BLOOM_BIT];
    assign acc_set  = set_of(acc.addr);
    assign acc_tag  = tag_of(acc.addr);
    assign snp_set  = set_of(snoop.addr);
    assign ev_way   = WAY_W'(evict.way);
    assign ev_rd    = rd_ff[evict.set][ev_way];

    always_comb begin
        a_hit    = '0;
        a_free   = '0;
        a_ronly  = '0;
        s_hit_rd = '0;
        s_hit_wr = '0;
        for (int w = 0; w < WAYS; w++) begin
            a_free[w]  = !(rd_ff[acc_set][w] | wr_ff[acc_set][w]);
            a_hit[w]   = !a_free[w] && tag_ff[acc_set][w] == acc_tag;
            a_ronly[w] = rd_ff[acc_set][w] & ~wr_ff[acc_set][w];
            s_hit_rd[w] = rd_ff[snp_set][w] &&
                          tag_ff[snp_set][w] == tag_of(snoop.addr);
            s_hit_wr[w] = wr_ff[snp_set][w] &&
                          tag_ff[snp_set][w] == tag_of(snoop.addr);
        end
    end

    // Way choice; a full set of written lines cannot grow
    always_comb begin
        way_sel  = '0;
        spill    = 1'b0;
        cap_fail = 1'b0;
        if (|a_hit) begin
            way_sel = first_one(a_hit);
        end else if (|a_free) begin
            way_sel = first_one(a_free);
        end else if (|a_ronly && bloom_en) begin
            way_sel = first_one(a_ronly);
            spill   = 1'b1;
        end else begin
            cap_fail = 1'b1;
        end
    end

    // Remote accesses against our sets and the filter
    assign snp_conflict = snoop.valid && in_tx &&
        ((snoop.write && (|s_hit_rd || |s_hit_wr || (bloom_en &&
          bloom_ff[bloom_idx(tag_of(snoop.addr), snp_set)]))) ||
         (!snoop.write && |s_hit_wr));
    assign snp_lock = state_ff == ST_ELIDED &&
        snoop.addr[ADDR_W-1:LINE_OFS_W] == lock_addr_ff[ADDR_W-1:LINE_OFS_W];

    assign lk_exact = acc.addr == lock_addr_ff && acc.size_log2 == lock_size_ff;
    assign lk_ovl = acc.addr <= last_byte(lock_addr_ff, lock_size_ff) &&
                    lock_addr_ff <= last_byte(acc.addr, acc.size_log2);
    assign cross_line = acc.addr[ADDR_W-1:LINE_OFS_W] !=
        last_byte(acc.addr, acc.size_log2)[ADDR_W-1:LINE_OFS_W];
    // Release must restore the pre-acquire value
    assign rel_ok = lk_exact && ((acc.store_data ^ lock_val_ff) &
                    size_mask(lock_size_ff)) == '0;
    // Only the release may write the lock
    assign lock_viol = acc.valid && state_ff == ST_ELIDED &&
        (acc.rel_prefix ? !rel_ok : (lk_ovl && (acc.write || !lk_exact)));

    // Vector mixing and upper clear, each switchable
    assign vec_abort = (ctrl_ff[CTRL_VMIX_BIT] &&
        (core_ev.narrow_vector_ops || narrow_used_ff) &&
        (core_ev.wide_vector_ops || wide_used_ff)) ||
        (ctrl_ff[CTRL_VZU_BIT] && core_ev.upper_vector_clear);

    // Sibling eviction of a written line, or unfilterable read line
    assign ev_fail = evict.valid && (wr_ff[evict.set][ev_way] ||
                     (ev_rd && !bloom_en));

    // Abort priority: instruction-level and event causes first, then memory causes
    always_comb begin
        nxt_cause   = CAUSE_NONE;
        do_commit   = 1'b0;
        do_mark     = 1'b0;
        start_elide = 1'b0;
        suppress    = 1'b0;
        if (in_tx) begin
            if (core_ev.explicit_abort_instr) begin
                nxt_cause = CAUSE_EXPLICIT;
            // Exception suppressed, re-raised on the fallback path
            end else if (core_ev.sync_exception) begin
                nxt_cause = CAUSE_EVENT;
                suppress  = 1'b1;
            end else if (core_ev.async_event) begin
                nxt_cause = CAUSE_EVENT;
            end else if (core_ev.instr_class_abort ||
                         core_ev.page_flag_update || vec_abort) begin
                nxt_cause = CAUSE_INSTR;
            end else if (snp_conflict) begin
                nxt_cause = snp_lock ? CAUSE_LOCK : CAUSE_CONFLICT;
            end else if (lock_viol) begin
                nxt_cause = CAUSE_LOCK;
            // Capacity can also fail below the set limit
            end else if ((acc.valid && cap_fail &&
                          !(acc.rel_prefix && state_ff == ST_ELIDED)) ||
                         ev_fail) begin
                nxt_cause = CAUSE_CAPACITY;
            end else if (acc.valid && acc.rel_prefix &&
                         state_ff == ST_ELIDED) begin
                // Release store is elided, not buffered
                do_commit = 1'b1;
            end else begin
                do_mark   = acc.valid;
                do_commit = core_ev.tx_commit && state_ff == ST_EXPLICIT;
            end
        end else if (!core_ev.tx_begin && acc.valid && acc.acq_prefix &&
                     acc.write) begin
            if (cross_line) begin
                nxt_cause = CAUSE_LOCK;
            end else if (cap_fail) begin
                nxt_cause = CAUSE_CAPACITY;
            end else begin
                start_elide = 1'b1;
                do_mark     = 1'b1;
            end
        end
        do_abort = nxt_cause != CAUSE_NONE;
    end

    // Any abort returns to idle, handing over to the fallback path
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_ff  <= ST_IDLE;
            active_ff <= 1'b0;
        end else if (do_abort || do_commit) begin
            state_ff  <= ST_IDLE;
            active_ff <= 1'b0;
        end else if (start_elide) begin
            state_ff  <= ST_ELIDED;
            active_ff <= 1'b1;
        end else if (!in_tx && core_ev.tx_begin) begin
            state_ff  <= ST_EXPLICIT;
            active_ff <= 1'b1;
        end
    end

    // Set marks and filter cleared at every transaction end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int s = 0; s < SETS; s++) begin
                rd_ff[s] <= '0;
                wr_ff[s] <= '0;
            end
            bloom_ff <= '0;
        end else if (do_abort || do_commit) begin
            for (int s = 0; s < SETS; s++) begin
                rd_ff[s] <= '0;
                wr_ff[s] <= '0;
            end
            bloom_ff <= '0;
        end else begin
            // Sibling eviction moves a read line to the filter
            if (evict.valid && in_tx) begin
                rd_ff[evict.set][ev_way] <= 1'b0;
                wr_ff[evict.set][ev_way] <= 1'b0;
                if (ev_rd) begin
                    bloom_ff[bloom_idx(tag_ff[evict.set][ev_way],
                                       evict.set)] <= 1'b1;
                end
            end
            if (do_mark) begin
                if (spill) begin
                    bloom_ff[bloom_idx(tag_ff[acc_set][way_sel],
                                       acc_set)] <= 1'b1;
                end
                // Acquire marks the lock line as read only
                rd_ff[acc_set][way_sel] <= !spill &&
                    rd_ff[acc_set][way_sel] || !acc.write || start_elide;
                wr_ff[acc_set][way_sel] <= !spill &&
                    wr_ff[acc_set][way_sel] || acc.write && !start_elide;
            end
        end
    end

    // Tags are meaningful only under a mark bit, so they need no reset
    always_ff @(posedge pclk) begin
        if (do_mark) begin
            tag_ff[acc_set][way_sel] <= acc_tag;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_addr_ff <= '0;
            lock_size_ff <= '0;
            lock_val_ff  <= '0;
        end else if (start_elide) begin
            lock_addr_ff <= acc.addr;
            lock_size_ff <= acc.size_log2;
            lock_val_ff  <= acc.mem_data & size_mask(acc.size_log2);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            narrow_used_ff <= 1'b0;
            wide_used_ff   <= 1'b0;
        end else if (!in_tx || do_abort || do_commit) begin
            narrow_used_ff <= 1'b0;
            wide_used_ff   <= 1'b0;
        end else begin
            narrow_used_ff <= narrow_used_ff | core_ev.narrow_vector_ops;
            wide_used_ff   <= wide_used_ff | core_ev.wide_vector_ops;
        end
    end

    // Cause held until the next abort
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            abort_ff     <= 1'b0;
            commit_ff    <= 1'b0;
            supp_ff      <= 1'b0;
            cause_ff     <= CAUSE_NONE;
            abort_cnt_ff <= '0;
        end else begin
            abort_ff  <= do_abort;
            commit_ff <= do_commit;
            supp_ff   <= suppress;
            if (do_abort) begin
                cause_ff     <= nxt_cause;
                abort_cnt_ff <= abort_cnt_ff + CNT_W'(1);
            end
        end
    end

    // APB slave: one wait state, answer registered in the access phase
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
            ctrl_ff    <= CTRL_RESET;
        end else if (psel && penable && !pready_ff) begin
            pready_ff  <= 1'b1;
            pslverr_ff <= 1'b0;
            prdata_ff  <= '0;
            case (paddr)
                REG_CTRL: begin
                    if (pwrite) begin
                        ctrl_ff <= pwdata[CTRL_W-1:0];
                    end
                    prdata_ff[CTRL_W-1:0] <= ctrl_ff;
                end
                REG_STATUS: begin
                    prdata_ff[STATUS_STATE_LSB +: 2] <= state_ff;
                    prdata_ff[STATUS_CAUSE_LSB +: 3] <= cause_ff;
                end
                REG_ABORT_CNT: begin
                    prdata_ff[CNT_W-1:0] <= abort_cnt_ff;
                end
                default: begin
                    pslverr_ff <= 1'b1;
                end
            endcase
        end else begin
            pready_ff  <= 1'b0;
            pslverr_ff <= 1'b0;
        end
    end

    assign prdata       = prdata_ff;
    assign pready       = pready_ff;
    assign pslverr      = pslverr_ff;
    assign tx_active    = active_ff;
    assign abort_pulse  = abort_ff;
    assign abort_cause  = cause_ff;
    assign commit_pulse = commit_ff;
    assign exc_suppress = supp_ff;

    // Helpers read only by the checks below
    logic any_mark;
    logic lock_wr;
    always_comb begin
        any_mark = 1'b0;
        lock_wr  = 1'b0;
        for (int s = 0; s < SETS; s++) begin
            any_mark = any_mark | (|rd_ff[s]) | (|wr_ff[s]);
        end
        for (int w = 0; w < WAYS; w++) begin
            lock_wr = lock_wr | (wr_ff[set_of(lock_addr_ff)][w] &&
                tag_ff[set_of(lock_addr_ff)][w] == tag_of(lock_addr_ff));
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_elide_start;
        !in_tx && acc.valid && acc.acq_prefix && acc.write &&
        !core_ev.tx_begin && !cross_line && !cap_fail;
    endsequence

    sequence s_quiet_elided;
        state_ff == ST_ELIDED && !snoop.valid && !evict.valid &&
        core_ev == '0;
    endsequence

    a_explicit_abort: assert property (
        in_tx && core_ev.explicit_abort_instr |=>
            abort_pulse && abort_cause == CAUSE_EXPLICIT && !tx_active)
        else $error("explicit abort not taken");

    a_write_conflict: assert property (
        in_tx && snoop.valid && snoop.write && |s_hit_rd |=> abort_pulse)
        else $error("remote write to read set missed");

    a_abort_clears: assert property (
        abort_pulse |-> !any_mark && !tx_active)
        else $error("marks survive an abort");

    a_cause_latched: assert property (
        abort_pulse |-> abort_cause != CAUSE_NONE &&
            abort_cause == $past(nxt_cause))
        else $error("abort without cause");

    a_elide_no_write: assert property (
        s_elide_start |=> state_ff == ST_ELIDED && !lock_wr)
        else $error("elided lock entered write set");

    a_release_bad: assert property (
        s_quiet_elided ##0 acc.valid && acc.rel_prefix &&
            acc.addr != lock_addr_ff |=>
            abort_pulse && abort_cause == CAUSE_LOCK)
        else $error("mismatched release did not abort");

    a_lock_store: assert property (
        s_quiet_elided ##0 acc.valid && acc.write && !acc.rel_prefix &&
            lk_exact |=> abort_pulse ##1 !tx_active)
        else $error("plain store to lock did not abort");

    a_exc_suppress: assert property (
        in_tx && core_ev.sync_exception && !core_ev.explicit_abort_instr
            |=> exc_suppress && abort_pulse && !commit_pulse)
        else $error("exception not suppressed");

    a_instr_abort: assert property (
        in_tx && core_ev.instr_class_abort && !core_ev.explicit_abort_instr
            && !core_ev.sync_exception && !core_ev.async_event
            |=> abort_cause == CAUSE_INSTR)
        else $error("instruction abort miscategorised");

endmodule

//--- hw/tx_abort_pkg.sv
// Constants, types and carriers for the transactional abort tracker
package tx_abort_pkg;

    localparam int ADDR_W     = 32;
    localparam int DATA_W     = 64;
    localparam int LINE_OFS_W = 6;   // 64-byte coherence line
    localparam int SET_W      = 6;
    localparam int L1_SETS    = 64;
    localparam int L1_WAYS    = 8;
    localparam int EV_WAY_W   = 3;
    localparam int BLOOM_W    = 8;
    localparam int BLOOM_SIZE = 256;
    localparam int TAG_W      = ADDR_W - LINE_OFS_W - SET_W;
    localparam int CNT_W      = 16;

    // Register byte offsets on the APB port
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;
    localparam logic [11:0] REG_ABORT_CNT = 12'h008;

    // Control fields
    localparam int         CTRL_BLOOM_BIT = 0;
    localparam int         CTRL_VMIX_BIT  = 1;
    localparam int         CTRL_VZU_BIT   = 2;
    localparam int         CTRL_W         = 3;
    localparam logic [2:0] CTRL_RESET     = 3'h7;

    // Status fields
    localparam int STATUS_STATE_LSB = 0;
    localparam int STATUS_CAUSE_LSB = 2;

    typedef enum logic [1:0] {
        ST_IDLE     = 2'b00,
        ST_EXPLICIT = 2'b01,
        ST_ELIDED   = 2'b10
    } tx_state_e;

    typedef enum logic [2:0] {
        CAUSE_NONE     = 3'b000,
        CAUSE_CONFLICT = 3'b001,
        CAUSE_CAPACITY = 3'b010,
        CAUSE_LOCK     = 3'b011,
        CAUSE_INSTR    = 3'b100,
        CAUSE_EVENT    = 3'b101,
        CAUSE_EXPLICIT = 3'b110
    } abort_cause_e;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [1:0]        size_log2;
        logic              acq_prefix;
        logic              rel_prefix;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] store_data;
        logic [DATA_W-1:0] mem_data;
    } mem_access_s;

    typedef struct packed {
        logic              valid;
        logic              write;
        logic [ADDR_W-1:0] addr;
    } snoop_s;

    typedef struct packed {
        logic                valid;
        logic [SET_W-1:0]    set;
        logic [EV_WAY_W-1:0] way;
    } evict_s;

    typedef struct packed {
        logic tx_begin;
        logic tx_commit;
        logic explicit_abort_instr;
        logic instr_class_abort;
        logic narrow_vector_ops;
        logic wide_vector_ops;
        logic upper_vector_clear;
        logic async_event;
        logic sync_exception;
        logic page_flag_update;
    } core_event_s;

endpackage

//--- testbench/peer_model.sv
// Remote logical processor issuing coherence snoops and sibling evictions
module peer_model
    import tx_abort_pkg::*;
(
    input  wire logic pclk,
    output snoop_s    snoop,
    output evict_s    evict
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        snoop = '0;
        evict = '0;
    end
    // Idle address is inverted so a stale line never looks meaningful
    task automatic touch(input logic w, input logic [31:0] a);
        @(posedge pclk) snoop <= '{1'h1, w, a};
        @(posedge pclk) snoop <= '{1'h0, 1'h0, ~a};
    endtask
    // Sibling eviction of one way, held for a single cycle
    task automatic drop(input logic [5:0] s, input logic [2:0] w);
        @(posedge pclk) evict <= '{1'h1, s, w};
        @(posedge pclk) evict <= '{1'h0, ~s, ~w};
    endtask
endmodule

//--- testbench/tb.sv
// Self-checking bench for the transactional abort tracker
module tb
    import tx_abort_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic         pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0]  paddr = '0;
    logic [31:0]  pwdata = '0, prdata, rd;
    logic         pready, pslverr, er, tx_active, abort_pulse;
    logic         commit_pulse, exc_suppress;
    mem_access_s  acc = '0;
    core_event_s  core_ev = '0;
    snoop_s       snoop;
    evict_s       evict;
    abort_cause_e abort_cause;
    int           n_fail = 0, checks = 0, cyc = 0;
    always #5 pclk = ~pclk;
    tx_abort_tracker tx_abort_tracker_i (.pclk, .presetn, .paddr, .psel,
        .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr, .acc, .snoop,
        .evict, .core_ev, .tx_active, .abort_pulse, .abort_cause,
        .commit_pulse, .exc_suppress);
    peer_model peer_model_i (.pclk, .snoop, .evict);
    task automatic chk(input logic [31:0] got, exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %0h exp %0h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk) {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
        @(posedge pclk) penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        {psel, penable} <= 2'h0;
    endtask
    // Inputs are one-cycle pulses; results are judged just after the edge
    task automatic step;
        @(posedge pclk) begin
            acc <= '0;
            core_ev <= '0;
        end
        #1;
    endtask
    task automatic ev(input int k);
        @(posedge pclk) core_ev <= core_event_s'(10'h001 << k);
        step;
    endtask
    task automatic mem(input logic w, acq, rel, input logic [31:0] a, sd);
        @(posedge pclk) acc <= '{1'h1, w, 2'h2, acq, rel, a, 64'(sd), 64'h0};
        step;
    endtask
    task automatic ends(input logic ab, input logic [2:0] c);
        chk(abort_pulse, ab);
        chk(commit_pulse, !ab);
        chk(abort_cause, c);
        chk(tx_active, 0);
    endtask
    task automatic t_events;
        int         k[6] = '{7, 6, 3, 2, 1, 0};
        logic [2:0] c[6] = '{6, 4, 4, 5, 5, 4};
        foreach (k[i]) begin
            ev(9);
            chk(tx_active, 1);
            ev(k[i]);
            ends(1, c[i]);
            chk(exc_suppress, k[i] == 1);
        end
        ev(9);
        ev(5);
        chk(tx_active, 1);
        ev(4);
        ends(1, 3'h4);
        ev(9);
        ev(8);
        ends(0, 3'h4);
    endtask
    task automatic t_capacity;
        ev(9);
        for (int i = 0; i < 8; i++) mem(1, 0, 0, 32'(i) << 12 | 32'h140, 0);
        chk(tx_active, 1);
        mem(1, 0, 0, 32'h8140, 0);
        ends(1, 3'h2);
    endtask
    task automatic t_conflict;
        ev(9);
        mem(0, 0, 0, 32'h2000, 0);
        peer_model_i.touch(1, 32'h2038);
        #1 ends(1, 3'h1);
        ev(9);
        mem(1, 0, 0, 32'h3000, 0);
        peer_model_i.touch(0, 32'h3010);
        #1 ends(1, 3'h1);
    endtask
    // First access of a fresh transaction takes way 0 of its set
    task automatic t_evict;
        ev(9);
        mem(1, 0, 0, 32'h5000, 0);
        peer_model_i.drop(6'h00, 3'h0);
        #1 ends(1, 3'h2);
        ev(9);
        mem(0, 0, 0, 32'h5000, 0);
        peer_model_i.drop(6'h00, 3'h0);
        #1 chk(tx_active, 1);
        peer_model_i.touch(1, 32'h5000);
        #1 ends(1, 3'h1);
    endtask
    task automatic t_elide;
        mem(1, 1, 0, 32'h4000, 1);
        chk(tx_active, 1);
        mem(0, 0, 0, 32'h4000, 0);
        chk(tx_active, 1);
        mem(1, 0, 1, 32'h4000, 0);
        ends(0, 3'h1);
        mem(1, 1, 0, 32'h4000, 1);
        mem(1, 0, 1, 32'h4000, 5);
        ends(1, 3'h3);
        mem(1, 1, 0, 32'h4000, 1);
        peer_model_i.touch(1, 32'h4000);
        #1 ends(1, 3'h3);
        mem(1, 1, 0, 32'h4000, 1);
        mem(1, 0, 0, 32'h4000, 2);
        ends(1, 3'h3);
        mem(1, 1, 0, 32'h4000, 1);
        mem(1, 0, 1, 32'h4004, 0);
        ends(1, 3'h3);
        mem(1, 1, 0, 32'h403E, 1);
        ends(1, 3'h3);
        mem(1, 1, 0, 32'h4000, 1);
        mem(0, 0, 0, 32'h4002, 0);
        ends(1, 3'h3);
    endtask
    task automatic t_regs;
        apb(0, REG_ABORT_CNT, 0);
        chk(rd, 32'h12);
        apb(0, REG_STATUS, 0);
        chk(rd, 32'hC);
        apb(1, REG_CTRL, 32'h2);
        apb(0, REG_CTRL, 0);
        chk(rd, 32'h2);
        apb(0, 12'h00C, 0);
        chk(er, 1);
    endtask
    // Reset in mid-transaction must bring back the reset values of tx_active, abort_cause, CTRL and the abort count
    task automatic t_reset;
        ev(9);
        @(posedge pclk) presetn <= 1'h0;
        @(posedge pclk) presetn <= 1'h1;
        #1 chk(tx_active, 0);
        chk(abort_cause, 0);
        apb(0, REG_CTRL, 0);
        chk(rd, 32'h7);
        apb(0, REG_ABORT_CNT, 0);
        chk(rd, 32'h0);
    endtask
    task automatic final_report;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            final_report();
        end
    end
    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'h1;
        apb(0, REG_CTRL, 0);
        chk(rd, 32'h7);
        t_events();
        t_capacity();
        t_conflict();
        t_evict();
        t_elide();
        t_regs();
        t_reset();
        final_report();
    end
endmodule
